// file: shared/srw_pkg.sv
/*
  Constants, register map and carrier types for the system reset and
  watchdog block. Assumes a 125 MHz system clock and an AHB-Lite master.
*/
package srw_pkg;
  localparam int unsigned CLK_HZ           = 125_000_000;
  localparam int unsigned WD_OSC_HZ        = 128_000;
  localparam int unsigned WD_TICK_DIV      = CLK_HZ / WD_OSC_HZ;
  localparam int unsigned BOD_QUAL_NS      = 2000;
  localparam int unsigned BOD_QUAL_CYC     = (BOD_QUAL_NS * 125 + 999) / 1000;
  localparam int unsigned EXT_MIN_NS       = 2500;
  localparam int unsigned EXT_MIN_CYC      = (EXT_MIN_NS * 125 + 999) / 1000;
  localparam int unsigned CHG_WINDOW_CYC   = 4;
  localparam int unsigned WD_BASE_CYC      = 2048;
  localparam logic [3:0]  WD_PRESCALE_MAX  = 4'h9;
  // byte addresses of the registers
  localparam logic [7:0]  ADDR_WD_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_RST_FLAGS   = 8'h04;
  localparam logic [7:0]  ADDR_CTRL        = 8'h08;
  localparam logic [7:0]  ADDR_STATUS      = 8'h0C;
  // watchdog control field positions
  localparam int unsigned WDC_INT_FLAG     = 7;
  localparam int unsigned WDC_INT_EN       = 6;
  localparam int unsigned WDC_PRE3         = 5;
  localparam int unsigned WDC_CHG_EN       = 4;
  localparam int unsigned WDC_RST_EN       = 3;
  // reset flag positions
  localparam int unsigned RF_POWER         = 0;
  localparam int unsigned RF_EXTERNAL      = 1;
  localparam int unsigned RF_BROWNOUT      = 2;
  localparam int unsigned RF_WATCHDOG      = 3;
  localparam int unsigned RF_SCAN          = 4;
  localparam logic [7:0]  WD_CTRL_RESET    = 8'h00;
  localparam logic [4:0]  RST_FLAGS_RESET  = 5'h00;
  localparam logic [5:0]  DELAY_SEL_RESET  = 6'h00;

  typedef enum logic [2:0] {
    SRW_RUN     = 3'b001,
    SRW_HOLD    = 3'b010,
    SRW_STRETCH = 3'b100
  } srw_state_e;

  typedef struct packed {
    logic power_low;
    logic ext_pin_n;
    logic brownout_low;
    logic scan_reset;
  } srw_sources_s;

  typedef struct packed {
    logic       always_on;
    logic       ext_disable;
    logic       brownout_en;
    logic [1:0] startup_time;
    logic [3:0] clock_select;
  } srw_fuses_s;
endpackage : srw_pkg

// file: hdl/srw_top.sv
/*
  System reset combiner and watchdog timer with an AHB-Lite register slave.
  Assumes analog detectors and pins arrive asynchronous to clk, and the
  core pulses wd_restart for the restart instruction.
*/
`timescale 1ns/1ps
module srw_top
  import srw_pkg::*;
#(
  parameter int unsigned DELAY_UNIT_CYC = 8192,
  parameter int unsigned WD_TICK_CYC    = WD_TICK_DIV
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire srw_sources_s sources,
  input  wire srw_fuses_s   fuses,
  input  wire logic         comparator_bandgap_select,
  input  wire logic         adc_enable,
  input  wire logic         wd_restart,
  input  wire logic         wd_vector_taken,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic [31:0]       hrdata,
  output logic              hreadyout,
  output logic              hresp,
  output logic              sys_reset_n,
  output logic              port_reset_n,
  output logic              wd_irq,
  output logic              bandgap_enable
);
  // synchronisers
  logic [3:0] src_meta;
  logic [3:0] src_sync;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_meta <= 4'h0;
      src_sync <= 4'h0;
    end else begin
      src_meta <= {sources.power_low, ~sources.ext_pin_n, sources.brownout_low, sources.scan_reset};
      src_sync <= src_meta;
    end
  end
  wire power_low_s = src_sync[3];
  wire ext_low_s   = src_sync[2];
  wire bod_low_s   = src_sync[1];
  wire scan_s      = src_sync[0];

  // qualification counters
  logic [15:0] bod_cnt;
  logic [15:0] ext_cnt;
  wire bod_valid = bod_cnt >= 16'(BOD_QUAL_CYC);
  wire ext_valid = ext_cnt >= 16'(EXT_MIN_CYC);
  wire         bod_armed    = bod_low_s && fuses.brownout_en;
  wire         ext_armed    = ext_low_s && !fuses.ext_disable;
  wire [15:0]  bod_step     = bod_valid ? bod_cnt : bod_cnt + 16'h0001;
  wire [15:0]  ext_step     = ext_valid ? ext_cnt : ext_cnt + 16'h0001;
  wire [15:0]  next_bod_cnt = bod_armed ? bod_step : 16'h0000;
  wire [15:0]  next_ext_cnt = ext_armed ? ext_step : 16'h0000;

  // brown-out qualification, a short drop restarts it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bod_cnt <= 16'h0000;
    end else begin
      bod_cnt <= next_bod_cnt;
    end
  end

  // reset pin minimum pulse width
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_cnt <= 16'h0000;
    end else begin
      ext_cnt <= next_ext_cnt;
    end
  end

  // asynchronous forcing of the port reset
  wire ext_async   = !sources.ext_pin_n && !fuses.ext_disable;
  wire bod_async   = sources.brownout_low && fuses.brownout_en && bod_valid;
  wire async_force = sources.power_low | ext_async | bod_async | sources.scan_reset;

  // watchdog state
  logic [7:0]  wd_ctrl;
  logic [4:0]  rst_flags;
  logic [2:0]  chg_cnt;
  logic [15:0] tick_div;
  logic [20:0] wd_cnt;
  logic        wd_rst_pulse;

  wire wd_tick     = tick_div == 16'(WD_TICK_CYC - 1);
  wire [3:0] pre   = {wd_ctrl[WDC_PRE3], wd_ctrl[2:0]};
  wire [3:0] pre_c = (pre > WD_PRESCALE_MAX) ? WD_PRESCALE_MAX : pre;
  wire [20:0] wd_limit = 21'(WD_BASE_CYC) << pre_c;
  wire rst_en_eff  = fuses.always_on | wd_ctrl[WDC_RST_EN] | rst_flags[RF_WATCHDOG];
  wire int_en_eff  = !fuses.always_on & wd_ctrl[WDC_INT_EN];
  wire wd_running  = rst_en_eff | int_en_eff;
  wire wd_expire   = wd_running && wd_tick && (wd_cnt >= wd_limit - 21'h000001);
  wire exp_irq     = wd_expire && int_en_eff;
  wire exp_reset   = wd_expire && rst_en_eff && !int_en_eff;

  // reset sequencer
  srw_state_e  state;
  srw_state_e  next_state;
  logic [23:0] delay_cnt;
  wire any_src     = power_low_s | ext_valid | bod_valid | scan_s;
  wire [23:0] delay_len = 24'(DELAY_UNIT_CYC) * {18'h0, fuses.startup_time, fuses.clock_select}
                          + 24'(DELAY_UNIT_CYC);
  always_comb begin
    next_state = state;
    unique case (state)
      SRW_RUN:     if (any_src || wd_rst_pulse) next_state = SRW_HOLD;
      SRW_HOLD:    if (!any_src) next_state = SRW_STRETCH;
      SRW_STRETCH: if (any_src) next_state = SRW_HOLD;
                   else if (delay_cnt == 24'h000000) next_state = SRW_RUN;
      default:     next_state = SRW_HOLD;
    endcase
  end

  wire         stretch_entry  = (next_state == SRW_STRETCH) && (state != SRW_STRETCH);
  wire         delay_running  = delay_cnt != 24'h000000;
  wire [23:0]  delay_load     = delay_len - 24'h000001;
  wire [23:0]  delay_dec      = delay_running ? delay_cnt - 24'h000001 : 24'h000000;
  wire [23:0]  next_delay_cnt = stretch_entry ? delay_load : delay_dec;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SRW_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // stretch counter, loaded as the last source goes quiet
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      delay_cnt <= 24'h000000;
    end else begin
      delay_cnt <= next_delay_cnt;
    end
  end

  wire hold_reset = any_src | wd_rst_pulse | (state != SRW_RUN);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sys_reset_n <= 1'b0;
    else        sys_reset_n <= !hold_reset;
  end

  // port reset: cleared asynchronously by power, scan, enabled pin and qualified brown-out; watchdog on the clock
  wire port_clr_n = rst_n & !async_force;
  always_ff @(posedge clk or negedge port_clr_n) begin
    if (!port_clr_n) port_reset_n <= 1'b0;
    else             port_reset_n <= !hold_reset;
  end

  wire next_wd_irq  = wd_ctrl[WDC_INT_FLAG] & int_en_eff;
  wire next_bandgap = fuses.brownout_en | comparator_bandgap_select | adc_enable;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_irq <= 1'b0;
    end else begin
      wd_irq <= next_wd_irq;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bandgap_enable <= 1'b0;
    end else begin
      bandgap_enable <= next_bandgap;
    end
  end

  // AHB-Lite slave, zero wait states
  logic        ph_write;
  logic        ph_read;
  logic [7:0]  ph_addr;
  wire         take     = hsel && hready && htrans[1];
  wire         take_wr  = take && hwrite;
  wire         take_rd  = take && !hwrite;
  wire [7:0]   req_addr = haddr[7:0];
  wire         wr_ctrl  = ph_write && ph_addr == ADDR_WD_CTRL;
  wire         wr_flags = ph_write && ph_addr == ADDR_RST_FLAGS;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_write <= 1'b0;
    end else begin
      ph_write <= take_wr;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_read <= 1'b0;
    end else begin
      ph_read <= take_rd;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_addr <= 8'h00;
    end else begin
      ph_addr <= take ? req_addr : ph_addr;
    end
  end

  // read words, chosen from the address phase
  wire         sel_ctrl    = req_addr == ADDR_WD_CTRL;
  wire         sel_flags   = req_addr == ADDR_RST_FLAGS;
  wire         sel_window  = req_addr == ADDR_CTRL;
  wire         sel_status  = req_addr == ADDR_STATUS;
  wire [31:0]  rd_ctrl     = {24'h000000, wd_ctrl[7:4], rst_en_eff, wd_ctrl[2:0]};
  wire [31:0]  rd_flags    = {27'h0, rst_flags};
  wire [31:0]  rd_window   = {29'h0, chg_cnt};
  wire [31:0]  rd_status   = {29'h0, state};
  wire [31:0]  rd_low      = sel_window ? rd_window : sel_status ? rd_status : 32'h00000000;
  wire [31:0]  rd_mux      = sel_ctrl ? rd_ctrl : sel_flags ? rd_flags : rd_low;
  wire [31:0]  next_hrdata = take_rd ? rd_mux : hrdata;

  // registered at the address phase, stands through the data phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) hrdata <= 32'h00000000;
    else        hrdata <= next_hrdata;
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  wire _unused = ph_read ^ hsize[0];

  // control register writes with timed change sequence
  wire        win_open    = chg_cnt != 3'h0;
  wire [7:0]  wv          = hwdata[7:0];
  wire        wv_rst_en   = wv[WDC_RST_EN];
  wire        wv_chg_en   = wv[WDC_CHG_EN];
  wire [3:0]  wv_pre      = {wv[WDC_PRE3], wv[2:0]};
  wire        open_req    = wr_ctrl && wv_chg_en && wv_rst_en;
  wire        prot_ok     = win_open && !wv_chg_en;
  wire        rst_en_wr   = wr_ctrl && (prot_ok || wv_rst_en);
  wire        rst_en_kept = rst_en_wr ? wv_rst_en : wd_ctrl[WDC_RST_EN];
  wire        next_rst_en = fuses.always_on ? 1'b1 : rst_en_kept;
  wire [3:0]  next_pre    = (wr_ctrl && prot_ok) ? wv_pre : pre;
  // combined mode drops to reset mode once the vector is taken
  wire        vec_to_rst  = wd_vector_taken && wd_ctrl[WDC_RST_EN];
  wire        ie_kept     = wr_ctrl ? wv[WDC_INT_EN] : vec_to_rst ? 1'b0 : wd_ctrl[WDC_INT_EN];
  wire        next_ie     = fuses.always_on ? 1'b0 : ie_kept;
  wire        if_clear    = (wr_ctrl && wv[WDC_INT_FLAG]) || wd_vector_taken;
  wire        next_if     = exp_irq || (wd_ctrl[WDC_INT_FLAG] && !if_clear);
  wire [2:0]  chg_dec     = (win_open && !wr_ctrl) ? chg_cnt - 3'h1 : 3'h0;
  wire [2:0]  next_chg    = open_req ? 3'(CHG_WINDOW_CYC) : chg_dec;
  wire        next_ce     = next_chg != 3'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_ctrl <= WD_CTRL_RESET;
    end else begin
      wd_ctrl <= {next_if, next_ie, next_pre[3], next_ce, next_rst_en, next_pre[2:0]};
    end
  end

  // change window, closed by any control write except one setting WDC_CHG_EN and WDC_RST_EN, which reloads it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chg_cnt <= 3'h0;
    end else begin
      chg_cnt <= next_chg;
    end
  end

  // watchdog counter and prescaler tick
  wire [15:0] next_tick_div = wd_tick ? 16'h0000 : tick_div + 16'h0001;
  wire        wd_clear      = wd_restart || !wd_running || wd_expire;
  wire [20:0] wd_step       = wd_tick ? wd_cnt + 21'h000001 : wd_cnt;
  wire [20:0] next_wd_cnt   = wd_clear ? 21'h000000 : wd_step;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_div <= 16'h0000;
    end else begin
      tick_div <= next_tick_div;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_cnt <= 21'h000000;
    end else begin
      wd_cnt <= next_wd_cnt;
    end
  end

  // one-cycle reset request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_rst_pulse <= 1'b0;
    end else begin
      wd_rst_pulse <= exp_reset;
    end
  end

  // reset flags, set wins over software clear
  wire [4:0] set_flags  = {scan_s, wd_rst_pulse, bod_valid, ext_valid, power_low_s};
  wire [4:0] kept_flags = wr_flags ? (rst_flags & hwdata[4:0]) : rst_flags;
  wire [4:0] next_flags = power_low_s ? 5'h01 : set_flags | kept_flags;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rst_flags <= RST_FLAGS_RESET;
    else        rst_flags <= next_flags;
  end
endmodule : srw_top

// file: tb/srw_assertions.sv
/* Checker on the srw_top ports.
   Bound from the testbench top file. */
`timescale 1ns/1ps
module srw_assertions
  import srw_pkg::*;
#(parameter int unsigned DELAY_UNIT_CYC = 8192) (
  input wire logic         clk,
  input wire logic         rst_n,
  input wire srw_sources_s sources,
  input wire srw_fuses_s   fuses,
  input wire logic         comparator_bandgap_select,
  input wire logic         adc_enable,
  input wire logic         wd_vector_taken,
  input wire logic         sys_reset_n,
  input wire logic         port_reset_n,
  input wire logic         wd_irq,
  input wire logic         bandgap_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] quiet;
  wire         bg_req = fuses.brownout_en | comparator_bandgap_select | adc_enable;
  wire         src_on = sources.power_low | sources.scan_reset | (sources.brownout_low & fuses.brownout_en)
                      | (~sources.ext_pin_n & ~fuses.ext_disable);
  // cycles since every enabled source went quiet
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) quiet <= 16'h0000;
    else if (src_on) quiet <= 16'h0000;
    else if (quiet != 16'hFFFF) quiet <= quiet + 16'h0001;
  end
  sequence s_low_soon; ##[0:3] !sys_reset_n; endsequence
  property p_bandgap; 1'b1 |=> bandgap_enable == $past(bg_req); endproperty
  a_bandgap: assert property (p_bandgap) else $error("bandgap enable wrong");
  property p_port; (sources.power_low || sources.scan_reset) |-> !port_reset_n; endproperty
  a_port: assert property (p_port) else $error("ports not held in reset");
  property p_scan; sources.scan_reset [*4] |-> !sys_reset_n; endproperty
  a_scan: assert property (p_scan) else $error("scan reset not held");
  property p_power; $rose(sources.power_low) |-> s_low_soon; endproperty
  a_power: assert property (p_power) else $error("power drop reset late");
  property p_stretch; $rose(sys_reset_n) |-> quiet >= DELAY_UNIT_CYC - 1; endproperty
  a_stretch: assert property (p_stretch) else $error("reset released early");
  property p_vec; wd_vector_taken |-> ##2 !wd_irq; endproperty
  a_vec: assert property (p_vec) else $error("vector left request");
  property p_always; fuses.always_on |-> !wd_irq; endproperty
  a_always: assert property (p_always) else $error("request under always-on");
  property p_sysrst; !sys_reset_n [*2] |-> !wd_irq; endproperty
  a_sysrst: assert property (p_sysrst) else $error("request during reset");
endmodule : srw_assertions

// file: tb/srw_core_model.sv
/* Core model: restarts the watchdog and takes its vector.
   Held in reset while the system reset is low. */
`timescale 1ns/1ps
module srw_core_model (
  input  wire logic clk,
  input  wire logic sys_reset_n,
  input  wire logic wd_irq,
  input  wire logic kick_en,
  input  wire logic svc_en,
  output logic      wd_restart,
  output logic      wd_vector_taken
);
  logic [9:0] cnt;
  logic [1:0] dly;
  always_ff @(posedge clk or negedge sys_reset_n) begin
    if (!sys_reset_n) begin
      cnt <= 10'h000;
      dly <= 2'h0;
      wd_restart <= 1'b0;
      wd_vector_taken <= 1'b0;
    end else begin
      cnt <= cnt + 10'h001;
      wd_restart <= kick_en & (cnt == 10'h000);
      dly <= (wd_irq & svc_en) ? dly + 2'h1 : 2'h0;
      wd_vector_taken <= wd_irq & svc_en & (dly == 2'h3);
    end
  end
endmodule : srw_core_model

// file: tb/testbench.sv
/* Self-checking bench for srw_top.
   Drives bus, sources and fuses; the core model restarts the watchdog. */
`timescale 1ns/1ps
module testbench;
  import srw_pkg::*;
  logic         clk, rst_n, cmp_bg, adc_en, kick_en, svc_en, wd_restart, wd_vector_taken;
  logic         hreadyout, hresp, sys_reset_n, port_reset_n, wd_irq, bandgap_enable;
  logic [1:0]   htrans;
  logic         hwrite;
  logic [31:0]  haddr, hwdata, hrdata;
  srw_sources_s src;
  srw_fuses_s   fu;
  int           error_cnt, check_count, cyc;
  srw_top #(.DELAY_UNIT_CYC(4), .WD_TICK_CYC(4)) srw_top_i (.clk(clk), .rst_n(rst_n), .sources(src),
    .fuses(fu), .comparator_bandgap_select(cmp_bg), .adc_enable(adc_en), .wd_restart(wd_restart),
    .wd_vector_taken(wd_vector_taken), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sys_reset_n(sys_reset_n), .port_reset_n(port_reset_n), .wd_irq(wd_irq),
    .bandgap_enable(bandgap_enable));
  srw_core_model srw_core_model_i (.clk(clk), .sys_reset_n(sys_reset_n), .wd_irq(wd_irq),
    .kick_en(kick_en), .svc_en(svc_en), .wd_restart(wd_restart), .wd_vector_taken(wd_vector_taken));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict
  always @(posedge clk) begin
    cyc++;
    if (cyc == 95000) begin
      error_cnt++;
      $display("ERROR %0t timeout", $time);
      give_verdict();
    end
  end
  task automatic check(input logic act, input logic exp);
    check_count++;
    if (act !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %b want %b", $time, act, exp);
    end
  endtask : check
  function automatic logic sig(input bit s);
    return s ? wd_irq : sys_reset_n;
  endfunction : sig
  task automatic wait_for(input bit s, input logic v, input int n);
    int i;
    i = 0;
    do @(negedge clk); while (sig(s) !== v && ++i < n);
    check(sig(s), v);
  endtask : wait_for
  task automatic hold(input bit s, input logic v, input int n);
    repeat (n) begin
      @(negedge clk);
      check(sig(s), v);
    end
  endtask : hold
  task automatic ahb_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask : ahb_write
  task automatic ahb_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    do @(posedge clk); while (hreadyout !== 1'b1);
    d = hrdata;
    hwrite <= 1'b1;
  endtask : ahb_read
  task automatic t_power();
    @(posedge clk) src.power_low <= 1'b1;
    @(negedge clk) check(port_reset_n, 1'b0);
    wait_for(0, 1'b0, 4);
    @(posedge clk) src.power_low <= 1'b0;
    hold(0, 1'b0, 5);
    wait_for(0, 1'b1, 20);
    $display("power test done");
  endtask : t_power
  task automatic t_scan();
    @(posedge clk) {src.scan_reset, fu.always_on} <= 2'h3;
    wait_for(0, 1'b0, 4);
    hold(0, 1'b0, 40);
    @(posedge clk) {src.scan_reset, fu.always_on} <= 2'h0;
    wait_for(0, 1'b1, 20);
    $display("scan test done");
  endtask : t_scan
  task automatic t_ext();
    @(posedge clk) {fu.ext_disable, src.ext_pin_n} <= 2'h2;
    hold(0, 1'b1, 400);
    @(posedge clk) fu.ext_disable <= 1'b0;
    wait_for(0, 1'b0, 400);
    @(posedge clk) src.ext_pin_n <= 1'b1;
    wait_for(0, 1'b1, 30);
    $display("external test done");
  endtask : t_ext
  task automatic t_bod();
    @(posedge clk) {fu.brownout_en, src.brownout_low} <= 2'h3;
    hold(0, 1'b1, 100);
    @(posedge clk) src.brownout_low <= 1'b0;
    hold(0, 1'b1, 10);
    @(posedge clk) src.brownout_low <= 1'b1;
    hold(0, 1'b1, 240);
    wait_for(0, 1'b0, 30);
    @(posedge clk) src.brownout_low <= 1'b0;
    hold(0, 1'b0, 5);
    wait_for(0, 1'b1, 30);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk) {fu.brownout_en, cmp_bg, adc_en} <= i[2:0];
      repeat (2) @(negedge clk);
      check(bandgap_enable, |i[2:0]);
    end
    $display("brown-out test done");
  endtask : t_bod
  task automatic t_wd_reset();
    logic [31:0] rd;
    @(posedge clk) kick_en <= 1'b1;
    ahb_write(ADDR_WD_CTRL, 8'h08);
    hold(0, 1'b1, 5000);
    ahb_write(ADDR_WD_CTRL, 8'h00);
    ahb_write(8'h40, 8'h00);
    ahb_write(ADDR_WD_CTRL, 8'h18);
    repeat (6) @(posedge clk);
    ahb_write(ADDR_WD_CTRL, 8'h00);
    @(posedge clk) kick_en <= 1'b0;
    hold(0, 1'b1, 7000);
    wait_for(0, 1'b0, 1400);
    wait_for(0, 1'b1, 40);
    hold(0, 1'b1, 7000);
    wait_for(0, 1'b0, 1400);
    wait_for(0, 1'b1, 40);
    ahb_read(ADDR_RST_FLAGS, rd);
    check(rd[RF_WATCHDOG], 1'b1);
    ahb_read(ADDR_WD_CTRL, rd);
    check(rd[WDC_RST_EN], 1'b1);
    ahb_write(ADDR_RST_FLAGS, 8'h00);
    ahb_write(ADDR_WD_CTRL, 8'h18);
    ahb_write(ADDR_WD_CTRL, 8'h00);
    hold(0, 1'b1, 9000);
    $display("watchdog reset test done");
  endtask : t_wd_reset
  task automatic t_wd_irq();
    ahb_write(ADDR_WD_CTRL, 8'h40);
    wait_for(1, 1'b1, 8400);
    check(sys_reset_n, 1'b1);
    @(posedge clk) svc_en <= 1'b1;
    wait_for(1, 1'b0, 8);
    ahb_write(ADDR_WD_CTRL, 8'h48);
    wait_for(1, 1'b1, 8400);
    wait_for(1, 1'b0, 8);
    wait_for(0, 1'b0, 8400);
    $display("watchdog interrupt test done");
  endtask : t_wd_irq
  initial begin
    {rst_n, cmp_bg, adc_en, kick_en, svc_en, htrans} = '0;
    {haddr, hwdata, error_cnt, check_count, cyc} = '0;
    hwrite = 1'b1;
    src = 4'h4;
    fu = '0;
    repeat (9) @(posedge clk);
    @(negedge clk) check(port_reset_n, 1'b0);
    check(sys_reset_n, 1'b0);
    @(posedge clk) rst_n <= 1'b1;
    wait_for(0, 1'b1, 40);
    t_power();
    t_scan();
    t_ext();
    t_bod();
    t_wd_reset();
    t_wd_irq();
    give_verdict();
  end
endmodule : testbench
bind srw_top srw_assertions #(.DELAY_UNIT_CYC(DELAY_UNIT_CYC)) srw_assertions_i (.clk(clk), .rst_n(rst_n),
  .sources(sources), .fuses(fuses), .comparator_bandgap_select(comparator_bandgap_select),
  .adc_enable(adc_enable), .wd_vector_taken(wd_vector_taken), .sys_reset_n(sys_reset_n),
  .port_reset_n(port_reset_n), .wd_irq(wd_irq), .bandgap_enable(bandgap_enable));
